// ### inc/ceu_params.svh
// Constants of the exception entry unit: vectors, modes, bank layout and timing.
`ifndef CEU_PARAMS_SVH
`define CEU_PARAMS_SVH

// ==========================================================
// Vector table, one word per slot
`define CEU_VEC_RESET 32'h0000_0000
`define CEU_VEC_UNDEF 32'h0000_0004
`define CEU_VEC_SWCALL 32'h0000_0008
`define CEU_VEC_PABT 32'h0000_000C
`define CEU_VEC_DABT 32'h0000_0010
`define CEU_VEC_RSVD 32'h0000_0014
`define CEU_VEC_IRQ 32'h0000_0018
`define CEU_VEC_FAST 32'h0000_001C

// ==========================================================
// Processing modes, used as bank and saved-state index
`define CEU_MODE_USR 3'h0
`define CEU_MODE_FAST 3'h1
`define CEU_MODE_IRQ 3'h2
`define CEU_MODE_ABT 3'h3
`define CEU_MODE_UND 3'h4
`define CEU_MODE_SVC 3'h5

// ==========================================================
// Physical register file layout
`define CEU_NUM_PHYS 31
`define CEU_FAST_BASE 5'h10
`define CEU_IRQ_BASE 5'h17
`define CEU_ABT_BASE 5'h19
`define CEU_UND_BASE 5'h1B
`define CEU_SVC_BASE 5'h1D
`define CEU_IDX_SP 4'hD
`define CEU_IDX_LINK 4'hE
`define CEU_IDX_PC 4'hF
`define CEU_IDX_R8 4'h8

// ==========================================================
// Transfer sizes and timing
`define CEU_SZ_8 2'h0
`define CEU_SZ_16 2'h1
`define CEU_SZ_32 2'h2
`define CEU_SZ_BAD 2'h3
`define CEU_PRIO_LEVELS 8
`define CEU_PRIO_W 3
`define CEU_MIN_INT_LAT 4'h5
`define CEU_LAT_MAX 4'hF

`endif

// ### inc/ceu_pkg.sv
// Types shared by the exception entry unit.
package ceu_pkg;
  typedef enum logic [2:0] {
    CEU_ST_IDLE  = 3'b001,
    CEU_ST_ENTER = 3'b010,
    CEU_ST_HALT  = 3'b100
  } ceu_state_e;
  typedef logic [2:0] ceu_mode_t;
  typedef logic [4:0] ceu_phys_t;
endpackage

// ### hw/ceu_prio_pick.sv
// Picks the highest-priority active source of one interrupt type.
`timescale 1ns/1ps
`include "ceu_params.svh"
module ceu_prio_pick #(
  parameter int N  = 4,
  parameter int LW = `CEU_PRIO_W,
  parameter int IW = 2
) (
  input  wire logic [N-1:0]    req,
  input  wire logic [N*LW-1:0] prio,
  output logic                 any,
  output logic [IW-1:0]        idx
);
  logic [LW-1:0] best;

  // Higher level wins; on a tie the lower source number wins.
  always_comb begin
    any  = 1'b0;
    idx  = '0;
    best = '0;
    for (int k = 0; k < N; k++) begin
      if (req[k] && (!any || prio[k*LW +: LW] > best)) begin
        any  = 1'b1;
        best = prio[k*LW +: LW];
        idx  = IW'(k);
      end
    end
  end
endmodule // ceu_prio_pick

// ### hw/ceu_exc_unit.sv
// Exception arbitration, vectoring, banked registers, multiplier and debug halt.
`timescale 1ns/1ps
`include "ceu_params.svh"
module ceu_exc_unit #(
  parameter int NF = 4,
  parameter int NI = 4,
  parameter int FW = (NF > 1) ? $clog2(NF) : 1,
  parameter int IW = (NI > 1) ? $clog2(NI) : 1
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [NF-1:0]            fast_interrupt_req,
  input  wire logic [NF*`CEU_PRIO_W-1:0] fast_interrupt_prio,
  input  wire logic [NI-1:0]            irq_req,
  input  wire logic [NI*`CEU_PRIO_W-1:0] irq_prio,
  input  wire logic                     data_abort,
  input  wire logic                     prefetch_abort,
  input  wire logic                     undef_instr,
  input  wire logic                     software_call_exception,
  input  wire logic [31:0]              cur_instr_addr,
  input  wire logic                     mem_req,
  input  wire logic [1:0]               mem_size,
  input  wire logic                     reg_wr,
  input  wire logic [3:0]               reg_wr_idx,
  input  wire logic [31:0]              reg_wr_data,
  input  wire logic [3:0]               reg_rd_idx,
  input  wire logic                     bl_valid,
  input  wire logic [31:0]              bl_return_addr,
  input  wire logic                     isa16_wr,
  input  wire logic                     isa16_wdata,
  input  wire logic                     exc_return,
  input  wire logic                     mul_start,
  input  wire logic                     mul_acc,
  input  wire logic                     mul_signed,
  input  wire logic [31:0]              mul_a,
  input  wire logic [31:0]              mul_b,
  input  wire logic [63:0]              mul_acc_in,
  input  wire logic                     fetch_valid,
  input  wire logic [31:0]              fetch_addr,
  input  wire logic                     data_valid,
  input  wire logic [31:0]              data_addr,
  input  wire logic                     dbg_cfg_wr,
  input  wire logic                     dbg_cfg_watch,
  input  wire logic [31:0]              dbg_cfg_addr,
  input  wire logic                     dbg_cfg_arm,
  input  wire logic                     dbg_reg_wr,
  input  wire logic [4:0]               dbg_reg_sel,
  input  wire logic [31:0]              dbg_reg_wdata,
  input  wire logic                     dbg_resume,
  output logic [31:0]                   program_counter_reg,
  output logic [31:0]                   reg_rd_data,
  output logic [2:0]                    cur_mode,
  output logic                          isa16_state,
  output logic [1:0]                    instr_size,
  output logic                          exc_taken,
  output logic [31:0]                   exc_vector,
  output logic [FW-1:0]                 fast_interrupt_src,
  output logic [IW-1:0]                 irq_src,
  output logic                          halted,
  output logic                          dbg_mem_grant,
  output logic [63:0]                   mul_result,
  output logic                          mul_done
);
  typedef struct packed {
    ceu_pkg::ceu_state_e st;
    ceu_pkg::ceu_mode_t  mode;
    ceu_pkg::ceu_mode_t  sel_mode;
    logic                isa16;
    logic [31:0]         sel_vec;
    logic                sel_int;
    logic [NF-1:0]       f1, f2, f3, fs;
    logic [NI-1:0]       i1, i2, i3, is;
    logic                p_dabt, p_pabt, p_swc, p_und;
    logic [`CEU_NUM_PHYS-1:0][31:0] regs;
    logic [5:0][3:0]     saved;
    logic [FW-1:0]       fid;
    logic [IW-1:0]       iid;
    logic [31:0]         rd_data;
    logic                taken;
    logic [31:0]         bp_addr, wp_addr;
    logic                bp_arm, wp_arm;
    logic [63:0]         mul_res;
    logic                mul_done;
    logic [3:0]          lat;
  } ceu_core_s;

  ceu_core_s s, n;
  logic f_any, i_any;
  logic [FW-1:0] f_idx;
  logic [IW-1:0] i_idx;

  // ==========================================================
  // Bank mapping
  // User-mode register number to physical slot under the given mode.
  function automatic ceu_pkg::ceu_phys_t phys(input ceu_pkg::ceu_mode_t m, input logic [3:0] r);
    ceu_pkg::ceu_phys_t b;
    b = `CEU_IRQ_BASE;
    phys = {1'b0, r};
    unique case (m)
      `CEU_MODE_ABT: b = `CEU_ABT_BASE;
      `CEU_MODE_UND: b = `CEU_UND_BASE;
      `CEU_MODE_SVC: b = `CEU_SVC_BASE;
      default:       b = `CEU_IRQ_BASE;
    endcase
    if (m == `CEU_MODE_FAST && r >= `CEU_IDX_R8 && r < `CEU_IDX_PC) begin
      phys = `CEU_FAST_BASE + {1'b0, r} - {1'b0, `CEU_IDX_R8};
    end else if (m != `CEU_MODE_USR && m != `CEU_MODE_FAST &&
                 (r == `CEU_IDX_SP || r == `CEU_IDX_LINK)) begin
      phys = b + {1'b0, r} - {1'b0, `CEU_IDX_SP};
    end
  endfunction

  // ==========================================================
  // Source prioritisers
  ceu_prio_pick #(.N(NF), .LW(`CEU_PRIO_W), .IW(FW)) u_fast_pick (
    .req  (s.fs),
    .prio (fast_interrupt_prio),
    .any  (f_any),
    .idx  (f_idx)
  );
  ceu_prio_pick #(.N(NI), .LW(`CEU_PRIO_W), .IW(IW)) u_irq_pick (
    .req  (s.is),
    .prio (irq_prio),
    .any  (i_any),
    .idx  (i_idx)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic fast_ok, irq_ok, bp_hit;
    logic [65:0] prod;
    fast_ok = f_any && s.mode != `CEU_MODE_FAST;
    irq_ok  = i_any && s.mode != `CEU_MODE_FAST && s.mode != `CEU_MODE_IRQ;
    bp_hit  = (s.bp_arm && fetch_valid && fetch_addr == s.bp_addr) ||
              (s.wp_arm && data_valid && data_addr == s.wp_addr);
    prod    = '0;
    n = s;
    n.taken    = 1'b0;
    n.mul_done = 1'b0;
    // Three-stage sync; a level counts once stages two and three agree.
    n.f1 = fast_interrupt_req;
    n.f2 = s.f1;
    n.f3 = s.f2;
    n.fs = (s.f2 & s.f3) | (s.fs & (s.f2 | s.f3));
    n.i1 = irq_req;
    n.i2 = s.i1;
    n.i3 = s.i2;
    n.is = (s.i2 & s.i3) | (s.is & (s.i2 | s.i3));
    unique case (s.st)
      ceu_pkg::CEU_ST_IDLE: begin
        if (reg_wr) begin
          n.regs[phys(s.mode, reg_wr_idx)] = reg_wr_data;
        end
        if (bl_valid) begin
          n.regs[phys(s.mode, `CEU_IDX_LINK)] = bl_return_addr;
        end
        if (isa16_wr) begin
          n.isa16 = isa16_wdata;
        end
        if (exc_return && s.mode != `CEU_MODE_USR) begin
          n.mode  = s.saved[s.mode][2:0];
          n.isa16 = s.saved[s.mode][3];
        end
        if (bp_hit) begin
          n.st = ceu_pkg::CEU_ST_HALT;
        end else begin
          n.st = ceu_pkg::CEU_ST_ENTER;
          // Fixed ladder; the reserved slot is never selected.
          if (s.p_dabt) begin
            n.sel_vec = `CEU_VEC_DABT;
            n.sel_mode = `CEU_MODE_ABT;
            n.p_dabt = 1'b0;
          end else if (fast_ok) begin
            n.sel_vec = `CEU_VEC_FAST;
            n.sel_mode = `CEU_MODE_FAST;
            n.fid = f_idx;
          end else if (irq_ok) begin
            n.sel_vec = `CEU_VEC_IRQ;
            n.sel_mode = `CEU_MODE_IRQ;
            n.iid = i_idx;
          end else if (s.p_pabt) begin
            n.sel_vec = `CEU_VEC_PABT;
            n.sel_mode = `CEU_MODE_ABT;
            n.p_pabt = 1'b0;
          end else if (s.p_swc) begin
            n.sel_vec = `CEU_VEC_SWCALL;
            n.sel_mode = `CEU_MODE_SVC;
            n.p_swc = 1'b0;
          end else if (s.p_und) begin
            n.sel_vec = `CEU_VEC_UNDEF;
            n.sel_mode = `CEU_MODE_UND;
            n.p_und = 1'b0;
          end else begin
            n.st = ceu_pkg::CEU_ST_IDLE;
          end
          n.sel_int = !s.p_dabt && (fast_ok || irq_ok);
        end
      end
      ceu_pkg::CEU_ST_ENTER: begin
        // Mode, saved state, link and vector all change on the same edge.
        n.mode = s.sel_mode;
        n.saved[s.sel_mode] = {s.isa16, s.mode};
        n.regs[phys(s.sel_mode, `CEU_IDX_LINK)] = cur_instr_addr;
        n.regs[`CEU_IDX_PC] = s.sel_vec;
        n.isa16 = 1'b0;
        n.taken = 1'b1;
        n.st = ceu_pkg::CEU_ST_IDLE;
      end
      ceu_pkg::CEU_ST_HALT: begin
        if (dbg_reg_wr && dbg_reg_sel < 5'(`CEU_NUM_PHYS)) begin
          n.regs[dbg_reg_sel] = dbg_reg_wdata;
        end
        if (dbg_resume) begin
          n.st = ceu_pkg::CEU_ST_IDLE;
        end
      end
    endcase
    // Arrivals win over the clear above; undefined yields to a call raised with it or pending, and a call yields to a pending undefined.
    if (data_abort || (mem_req && mem_size == `CEU_SZ_BAD)) begin
      n.p_dabt = 1'b1;
    end
    if (prefetch_abort) begin
      n.p_pabt = 1'b1;
    end
    if (software_call_exception && !s.p_und) begin
      n.p_swc = 1'b1;
    end
    if (undef_instr && !software_call_exception && !s.p_swc) begin
      n.p_und = 1'b1;
    end
    if (dbg_cfg_wr && dbg_cfg_watch) begin
      n.wp_addr = dbg_cfg_addr;
      n.wp_arm  = dbg_cfg_arm;
    end else if (dbg_cfg_wr) begin
      n.bp_addr = dbg_cfg_addr;
      n.bp_arm  = dbg_cfg_arm;
    end
    if (s.st == ceu_pkg::CEU_ST_HALT) begin
      n.rd_data = (dbg_reg_sel < 5'(`CEU_NUM_PHYS)) ? s.regs[dbg_reg_sel] : 32'h0000_0000;
    end else begin
      n.rd_data = s.regs[phys(s.mode, reg_rd_idx)];
    end
    if (mul_start) begin
      prod = 66'($signed({mul_signed & mul_a[31], mul_a}) *
                 $signed({mul_signed & mul_b[31], mul_b}));
      n.mul_res  = prod[63:0] + (mul_acc ? mul_acc_in : 64'h0000_0000_0000_0000);
      n.mul_done = 1'b1;
    end
    // Cycles for which some interrupt request has stood at the pins. It is not cleared on
    // entry, since a request queued behind another entry has still waited its full time.
    if (!(|fast_interrupt_req) && !(|irq_req)) begin
      n.lat = 4'h0;
    end else if (s.lat != `CEU_LAT_MAX) begin
      n.lat = s.lat + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= ceu_pkg::CEU_ST_IDLE;
      s.mode <= `CEU_MODE_SVC;
      s.regs[`CEU_IDX_PC] <= `CEU_VEC_RESET;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign program_counter_reg = s.regs[`CEU_IDX_PC];
  assign reg_rd_data         = s.rd_data;
  assign cur_mode            = s.mode;
  assign isa16_state         = s.isa16;
  assign instr_size          = s.isa16 ? `CEU_SZ_16 : `CEU_SZ_32;
  assign exc_taken           = s.taken;
  assign exc_vector          = s.regs[`CEU_IDX_PC];
  assign fast_interrupt_src  = s.fid;
  assign irq_src             = s.iid;
  assign halted              = s.st == ceu_pkg::CEU_ST_HALT;
  assign dbg_mem_grant       = s.st == ceu_pkg::CEU_ST_HALT;
  assign mul_result          = s.mul_res;
  assign mul_done            = s.mul_done;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_vec_not_rsvd: assert property (exc_taken |-> exc_vector != `CEU_VEC_RSVD)
    else $error("reserved vector taken");
  a_dabt_wins: assert property (s.st == ceu_pkg::CEU_ST_IDLE && s.p_dabt && !n.st[2]
    |=> s.sel_vec == `CEU_VEC_DABT ##1 exc_taken && cur_mode == `CEU_MODE_ABT)
    else $error("data abort not first");
  a_fast_over_irq: assert property (s.st == ceu_pkg::CEU_ST_IDLE && !s.p_dabt
    && f_any && i_any && s.mode != `CEU_MODE_FAST && !n.st[2] |=> s.sel_vec == `CEU_VEC_FAST)
    else $error("normal interrupt beat fast");
  a_call_undef_excl: assert property (!(s.p_swc && s.p_und))
    else $error("call and undefined both pending");
  a_entry_state: assert property (exc_taken |-> !isa16_state
    && cur_mode == $past(s.sel_mode) && program_counter_reg == $past(s.sel_vec))
    else $error("entry state wrong");
  a_link_saved: assert property (exc_taken
    |-> s.regs[phys(cur_mode, `CEU_IDX_LINK)] == $past(cur_instr_addr))
    else $error("link not saved");
  a_user_bank_kept: assert property (exc_taken
    |-> s.regs[`CEU_IDX_SP] == $past(s.regs[`CEU_IDX_SP])
    && s.regs[`CEU_IDX_LINK] == $past(s.regs[`CEU_IDX_LINK]))
    else $error("user stack or link changed");
  a_fast_r8_kept: assert property (exc_taken && cur_mode == `CEU_MODE_FAST
    |-> s.regs[`CEU_IDX_R8] == $past(s.regs[`CEU_IDX_R8]))
    else $error("fast entry touched r8");
  a_int_latency: assert property (exc_taken && $past(s.sel_int)
    |-> $past(s.lat) >= `CEU_MIN_INT_LAT - 4'h1)
    else $error("interrupt entry too fast");
  a_bp_halts: assert property (s.st == ceu_pkg::CEU_ST_IDLE && s.bp_arm
    && fetch_valid && fetch_addr == s.bp_addr |=> halted ##1 (halted || $past(dbg_resume)))
    else $error("breakpoint did not halt");
  a_mul_unsigned: assert property (mul_start && !mul_acc && !mul_signed
    |=> mul_done && mul_result == {32'h0000_0000, $past(mul_a)} * {32'h0000_0000, $past(mul_b)})
    else $error("multiply result wrong");

  c_fast_entry: cover property (exc_taken && cur_mode == `CEU_MODE_FAST);
  c_irq_entry: cover property (exc_taken && cur_mode == `CEU_MODE_IRQ);
  c_halt_resume: cover property (halted ##1 !halted);
  c_mac: cover property (mul_start && mul_acc ##1 mul_done);
endmodule // ceu_exc_unit

// ### testbench/ceu_vic_model.sv
// Interrupt controller model that holds each request until the core takes it.
`timescale 1ns/1ps
`include "ceu_params.svh"
module ceu_vic_model #(
  parameter int NF = 4,
  parameter int NI = 4
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [NF-1:0] set_fast,
  input  wire logic [NI-1:0] set_irq,
  input  wire logic          exc_taken,
  input  wire logic [31:0]   exc_vector,
  input  wire logic [1:0]    fast_interrupt_src,
  input  wire logic [1:0]    irq_src,
  output logic [NF-1:0]      fast_interrupt_req,
  output logic [NI-1:0]      irq_req
);
  typedef struct packed {
    logic [NF-1:0] fast;
    logic [NI-1:0] irq;
  } ceu_vic_s;
  ceu_vic_s st_ff;
  ceu_vic_s nxt_st;
  // ==========================================================
  // Request hold
  // The core does not latch interrupts, so a source drops only once its entry is seen.
  always_comb begin
    nxt_st = st_ff;
    if (exc_taken && exc_vector == `CEU_VEC_FAST) begin
      nxt_st.fast[fast_interrupt_src] = 1'b0;
    end
    if (exc_taken && exc_vector == `CEU_VEC_IRQ) begin
      nxt_st.irq[irq_src] = 1'b0;
    end
    nxt_st.fast = nxt_st.fast | set_fast;
    nxt_st.irq = nxt_st.irq | set_irq;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign fast_interrupt_req = st_ff.fast;
  assign irq_req = st_ff.irq;
endmodule // ceu_vic_model

// ### testbench/cpu_exception_entry_unit_tb.sv
// Self-checking testbench of the exception entry unit.
`timescale 1ns/1ps
`include "ceu_params.svh"
module cpu_exception_entry_unit_tb;
  localparam logic [5:0] PM [6] = '{6'h3F, 6'h1F, 6'h0E, 6'h07, 6'h03, 6'h01};
  localparam logic [31:0] PV [6] = '{`CEU_VEC_DABT, `CEU_VEC_FAST, `CEU_VEC_IRQ,
    `CEU_VEC_PABT, `CEU_VEC_SWCALL, `CEU_VEC_UNDEF};
  localparam logic [2:0] PD [6] = '{`CEU_MODE_ABT, `CEU_MODE_FAST, `CEU_MODE_IRQ,
    `CEU_MODE_ABT, `CEU_MODE_SVC, `CEU_MODE_UND};
  localparam logic [31:0] MA [3] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1000_0000};
  localparam logic [31:0] MB [3] = '{32'h0000_0002, 32'h0000_0003, 32'h0000_0010};
  localparam logic [63:0] MR [3] = '{64'h0000_0001_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFFD,
    64'h0000_0002_0000_0001};
  logic        clk, nrst, data_abort, prefetch_abort, undef_instr, software_call_exception;
  logic        mem_req, reg_wr, bl_valid, isa16_wr, isa16_wdata, exc_return, mul_start;
  logic        mul_acc, mul_signed, fetch_valid, data_valid, dbg_cfg_wr, dbg_cfg_watch;
  logic        dbg_cfg_arm, dbg_reg_wr, dbg_resume, isa16_state, exc_taken, halted;
  logic        dbg_mem_grant, mul_done;
  logic [1:0]  mem_size, instr_size, fast_interrupt_src, irq_src;
  logic [2:0]  cur_mode;
  logic [3:0]  fast_interrupt_req, irq_req, reg_wr_idx, reg_rd_idx, set_fast, set_irq;
  logic [4:0]  dbg_reg_sel;
  logic [11:0] fast_interrupt_prio, irq_prio;
  logic [31:0] cur_instr_addr, reg_wr_data, bl_return_addr, mul_a, mul_b, fetch_addr;
  logic [31:0] data_addr, dbg_cfg_addr, dbg_reg_wdata, program_counter_reg, reg_rd_data;
  logic [31:0] exc_vector;
  logic [63:0] mul_acc_in, mul_result;
  int          num_errors = 0, check_count = 0, cycles = 0, taken_cnt = 0;

  ceu_exc_unit #(.NF(4), .NI(4)) uut (
    .clk, .nrst, .fast_interrupt_req, .fast_interrupt_prio, .irq_req, .irq_prio,
    .data_abort, .prefetch_abort, .undef_instr, .software_call_exception, .cur_instr_addr,
    .mem_req, .mem_size, .reg_wr, .reg_wr_idx, .reg_wr_data, .reg_rd_idx, .bl_valid,
    .bl_return_addr, .isa16_wr, .isa16_wdata, .exc_return, .mul_start, .mul_acc,
    .mul_signed, .mul_a, .mul_b, .mul_acc_in, .fetch_valid, .fetch_addr, .data_valid,
    .data_addr, .dbg_cfg_wr, .dbg_cfg_watch, .dbg_cfg_addr, .dbg_cfg_arm, .dbg_reg_wr,
    .dbg_reg_sel, .dbg_reg_wdata, .dbg_resume, .program_counter_reg, .reg_rd_data,
    .cur_mode, .isa16_state, .instr_size, .exc_taken, .exc_vector, .fast_interrupt_src,
    .irq_src, .halted, .dbg_mem_grant, .mul_result, .mul_done);
  ceu_vic_model #(.NF(4), .NI(4)) vic (
    .clk, .nrst, .set_fast, .set_irq, .exc_taken, .exc_vector, .fast_interrupt_src,
    .irq_src, .fast_interrupt_req, .irq_req);

  // ==========================================================
  // Clock, entry counter and hang guard
  always #12.5 clk = ~clk;
  // The whole run needs about 260 cycles; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cycles++;
    if (exc_taken === 1'b1) taken_cnt++;
    if (cycles == 8000) begin
      num_errors++;
      finish_test;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_taken(output int cyc);
    cyc = 0;
    while (exc_taken !== 1'b1 && cyc < 40) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    check("exc_taken", exc_taken, 1'b1);
  endtask
  task automatic chk_reg(string name, logic [3:0] idx, logic [31:0] exp);
    @(posedge clk);
    reg_rd_idx <= idx;
    @(posedge clk);
    #1;
    check(name, reg_rd_data, exp);
  endtask
  task automatic wr_reg(logic [3:0] idx, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_wr_idx <= idx;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic ret;
    @(posedge clk);
    exc_return <= 1'b1;
    @(posedge clk);
    exc_return <= 1'b0;
  endtask
  task automatic resume;
    @(posedge clk);
    dbg_resume <= 1'b1;
    @(posedge clk);
    dbg_resume <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic halt_at(logic watch, logic [31:0] addr);
    @(posedge clk);
    dbg_cfg_wr <= 1'b1;
    dbg_cfg_watch <= watch;
    dbg_cfg_arm <= 1'b1;
    dbg_cfg_addr <= addr;
    @(posedge clk);
    dbg_cfg_wr <= 1'b0;
    fetch_valid <= !watch;
    fetch_addr <= addr;
    data_valid <= watch;
    data_addr <= addr;
    @(posedge clk);
    fetch_valid <= 1'b0;
    data_valid <= 1'b0;
    @(posedge clk);
    #1;
    check("halted", halted, 1'b1);
    check("dbg_mem_grant", dbg_mem_grant, 1'b1);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    check("cur_mode", cur_mode, `CEU_MODE_SVC);
    check("pc", program_counter_reg, `CEU_VEC_RESET);
    check("instr_size", instr_size, `CEU_SZ_32);
    check("halted", halted, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_abort;
    int cyc;
    int n0;
    wr_reg(`CEU_IDX_SP, 32'h0000_AAAA);
    @(posedge clk);
    bl_valid <= 1'b1;
    bl_return_addr <= 32'h0000_2000;
    isa16_wr <= 1'b1;
    isa16_wdata <= 1'b1;
    @(posedge clk);
    bl_valid <= 1'b0;
    isa16_wr <= 1'b0;
    #1;
    check("instr_size", instr_size, `CEU_SZ_16);
    chk_reg("link", `CEU_IDX_LINK, 32'h0000_2000);
    n0 = taken_cnt;
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      mem_req <= 1'b1;
      mem_size <= s[1:0];
      @(posedge clk);
      mem_req <= 1'b0;
    end
    repeat (6) @(posedge clk);
    check("legal sizes", taken_cnt, n0);
    @(posedge clk);
    cur_instr_addr <= 32'h0000_1234;
    mem_req <= 1'b1;
    mem_size <= `CEU_SZ_BAD;
    @(posedge clk);
    mem_req <= 1'b0;
    wait_taken(cyc);
    check("vector", exc_vector, `CEU_VEC_DABT);
    check("pc", program_counter_reg, `CEU_VEC_DABT);
    check("mode", cur_mode, `CEU_MODE_ABT);
    check("isa16_state", isa16_state, 1'b0);
    chk_reg("abort link", `CEU_IDX_LINK, 32'h0000_1234);
    chk_reg("abort sp", `CEU_IDX_SP, 32'h0000_0000);
    ret;
    chk_reg("svc sp", `CEU_IDX_SP, 32'h0000_AAAA);
    chk_reg("svc link", `CEU_IDX_LINK, 32'h0000_2000);
    $display("test abort done");
  endtask
  task automatic t_debug;
    halt_at(1'b1, 32'h0000_4000);
    @(posedge clk);
    dbg_reg_wr <= 1'b1;
    dbg_reg_sel <= 5'h14;
    dbg_reg_wdata <= 32'h0000_5A5A;
    @(posedge clk);
    dbg_reg_wr <= 1'b0;
    @(posedge clk);
    #1;
    check("debug slot", reg_rd_data, 32'h0000_5A5A);
    resume;
    #1;
    check("halted", halted, 1'b0);
    $display("test debug done");
  endtask
  task automatic t_irq;
    int cyc;
    int n0;
    @(posedge clk);
    irq_prio <= {3'h6, 3'h6, 3'h3, 3'h7};
    fast_interrupt_prio <= {3'h7, 3'h0, 3'h0, 3'h0};
    cur_instr_addr <= 32'h0000_0300;
    set_irq <= 4'b1110;
    @(posedge clk);
    set_irq <= 4'b0000;
    wait_taken(cyc);
    check("latency ok", cyc >= 5, 1'b1);
    check("vector", exc_vector, `CEU_VEC_IRQ);
    check("irq_src", irq_src, 2'h2);
    check("mode", cur_mode, `CEU_MODE_IRQ);
    chk_reg("irq link", `CEU_IDX_LINK, 32'h0000_0300);
    wr_reg(`CEU_IDX_R8, 32'h0000_0088);
    @(posedge clk);
    set_fast <= 4'b1000;
    @(posedge clk);
    set_fast <= 4'b0000;
    wait_taken(cyc);
    check("vector", exc_vector, `CEU_VEC_FAST);
    check("fast src", fast_interrupt_src, 2'h3);
    check("mode", cur_mode, `CEU_MODE_FAST);
    chk_reg("fast r8", `CEU_IDX_R8, 32'h0000_0000);
    n0 = taken_cnt;
    repeat (12) @(posedge clk);
    check("irq held off", taken_cnt, n0);
    ret;
    chk_reg("user r8", `CEU_IDX_R8, 32'h0000_0088);
    ret;
    wait_taken(cyc);
    check("irq_src", irq_src, 2'h3);
    $display("test irq done");
  endtask
  task automatic t_mul;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      mul_start <= 1'b1;
      mul_signed <= (i == 1);
      mul_acc <= (i == 2);
      mul_a <= MA[i];
      mul_b <= MB[i];
      mul_acc_in <= 64'h0000_0001_0000_0001;
      @(posedge clk);
      mul_start <= 1'b0;
      #1;
      check("mul_done", mul_done, 1'b1);
      check("mul_result", mul_result, MR[i]);
    end
    $display("test mul done");
  endtask
  // Causes are raised while halted so that all of them, except an undefined raised with a call, are pending at one decision.
  task automatic t_prio;
    int cyc;
    int n0;
    for (int i = 0; i < 6; i++) begin
      do_reset;
      halt_at(1'b0, 32'h0000_0100);
      @(posedge clk);
      {data_abort, set_fast[0], set_irq[0], prefetch_abort, software_call_exception,
       undef_instr} <= PM[i];
      @(posedge clk);
      {data_abort, set_fast[0], set_irq[0], prefetch_abort, software_call_exception,
       undef_instr} <= 6'h00;
      repeat (8) @(posedge clk);
      n0 = taken_cnt;
      resume;
      wait_taken(cyc);
      check("vector", exc_vector, PV[i]);
      check("mode", cur_mode, PD[i]);
      check("not reserved", exc_vector === `CEU_VEC_RSVD, 1'b0);
      if (i >= 4) begin
        repeat (12) @(posedge clk);
        check("single entry", taken_cnt - n0, 1);
      end
    end
    $display("test priority done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {data_abort, prefetch_abort, undef_instr, software_call_exception, mem_req, mem_size,
     reg_wr, reg_wr_idx, reg_wr_data, reg_rd_idx, bl_valid, bl_return_addr, isa16_wr,
     isa16_wdata, exc_return, mul_start, mul_acc, mul_signed, mul_a, mul_b, mul_acc_in,
     fetch_valid, fetch_addr, data_valid, data_addr, dbg_cfg_wr, dbg_cfg_watch,
     dbg_cfg_addr, dbg_cfg_arm, dbg_reg_wr, dbg_reg_sel, dbg_reg_wdata, dbg_resume,
     set_fast, set_irq, fast_interrupt_prio, irq_prio, cur_instr_addr} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_abort;
    t_debug;
    t_irq;
    t_mul;
    t_prio;
    finish_test;
  end
endmodule // cpu_exception_entry_unit_tb
